// ### rtl/train_mem.sv
// Purpose: five-entry storage for training bursts
// Assumes: one write and one read port, registered read data
// Notes:   unwritten entries hold whatever was there (undefined)
`timescale 1ns/1ps
module train_mem (
   input  wire logic                           core_clk_in,
   input  wire logic                           wr_en_in,
   input  wire logic [train_pkg::PTR_W-1:0]    wr_addr_in,
   input  wire logic [train_pkg::ENTRY_W-1:0]  wr_data_in,
   input  wire logic [train_pkg::PTR_W-1:0]    rd_addr_in,
   output logic      [train_pkg::ENTRY_W-1:0]  rd_data_out
);
   import train_pkg::*;

   logic [ENTRY_W-1:0] mem_ff [FIFO_DEPTH];

   always_ff @(posedge core_clk_in) begin
      if (wr_en_in) begin
         mem_ff[wr_addr_in] <= wr_data_in;
      end
   end

   always_ff @(posedge core_clk_in) begin
      rd_data_out <= mem_ff[rd_addr_in];
   end

endmodule

// ### rtl/train_osc_fifo.sv
// Purpose: training fifo and strobe clock-tree interval oscillator
// Assumes: commands decoded upstream; osc_tick_in is one replica-tree pass
// Notes:   latencies counted in clocks from the second-part command
`timescale 1ns/1ps
// Operation
// - fifo write accepted in banks, refresh, self-refresh
// - back-to-back fifo reads each served; here a read still waiting out rd_lat is dropped by the next read
// - fifo read data timed like single read
// - reads non-destructive; read pointer wraps after five
// - never-written entries read back undefined
// - drive mask lanes when inversion or masking enabled
// - sixteen-beat bursts, half-clock postambles; no postamble is driven here, output enables release right after the last beat
// - fifo write timed like single write
// - start command clears and runs oscillator
// - stop by command or run timer
// - count stored low/high on stop
// - stop command overwrites both result registers
// - counter saturates at maximum
// - result counts tree delays within run time
// - pointers reset on reset and power-down entry
// - pointer advance by fifo and ordinary reads
// - select bit low means no operation
module train_osc_fifo (
   input  wire logic                          core_clk_in,
   input  wire logic                          arst_n_in,
   input  wire train_pkg::cmd_s               cmd_in,
   input  wire train_pkg::mode_s              mode_in,
   input  wire logic                          clk_en_in,
   input  wire logic                          osc_tick_in,
   input  wire logic [train_pkg::DQ_W-1:0]    dq_in,
   input  wire logic [train_pkg::LANE_W-1:0]  lane_in,
   output logic      [train_pkg::DQ_W-1:0]    dq_out,
   output logic                               dq_oe_n_out,
   output logic      [train_pkg::LANE_W-1:0]  lane_out,
   output logic                               lane_oe_n_out,
   output logic      [train_pkg::TMR_W-1:0]   osc_count_low_out,
   output logic      [train_pkg::TMR_W-1:0]   osc_count_high_out,
   output logic                               osc_busy_out
);
   import train_pkg::*;

   // ------------------------------------------------------------------
   // command decode
   // ------------------------------------------------------------------
   logic        train_sel;
   logic        wr_fifo_cmd;
   logic        rd_fifo_cmd;
   logic        osc_start_cmd;
   logic        osc_stop_cmd;
   logic [1:0]  pend_ff;
   logic        wr_go;
   logic        rd_go;

   assign train_sel     = cmd_in.mpc_valid & cmd_in.mpc_op[SEL_BIT];
   assign wr_fifo_cmd   = train_sel & (cmd_in.mpc_op[5:0] == OP_WR_FIFO);
   assign rd_fifo_cmd   = train_sel & (cmd_in.mpc_op[5:0] == OP_RD_FIFO);
   assign osc_start_cmd = train_sel & (cmd_in.mpc_op[5:0] == OP_OSC_START);
   assign osc_stop_cmd  = train_sel & (cmd_in.mpc_op[5:0] == OP_OSC_STOP);

   // fifo access begins on the second-part command; accepted in any bank
   // or refresh state; writes need only clock enable high, reads are not gated by it
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pend_ff <= 2'b00;
      end else begin
         pend_ff <= {wr_fifo_cmd & clk_en_in, rd_fifo_cmd};
      end
   end

   // operands of the second-part command are ignored (driven low)
   assign wr_go = pend_ff[1] & cmd_in.cas2_valid;
   assign rd_go = pend_ff[0] & cmd_in.cas2_valid;

   // ------------------------------------------------------------------
   // fifo pointers
   // ------------------------------------------------------------------
   ptr_t wr_ptr_ff;
   ptr_t rd_ptr_ff;
   logic ptr_clr;
   ptr_t rd_slot_ff;

   assign ptr_clr = cmd_in.pd_entry | ~clk_en_in;

   function automatic ptr_t ptr_inc(input ptr_t p);
      ptr_inc = (p == PTR_LAST) ? PTR_RST : p + ptr_t'(1);
   endfunction

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         wr_ptr_ff <= PTR_RST;
      end else if (ptr_clr) begin
         wr_ptr_ff <= PTR_RST;
      end else if (wr_go | cmd_in.rd_valid) begin
         wr_ptr_ff <= ptr_inc(wr_ptr_ff);
      end
   end

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rd_ptr_ff <= PTR_RST;
      end else if (ptr_clr) begin
         rd_ptr_ff <= PTR_RST;
      end else if (rd_go | cmd_in.rd_valid) begin
         rd_ptr_ff <= ptr_inc(rd_ptr_ff);
      end
   end

   // ------------------------------------------------------------------
   // write burst capture
   // ------------------------------------------------------------------
   xfer_state_e           wr_state_ff;
   logic [LAT_W-1:0]      wr_lat_ff;
   logic [BEAT_CNT_W-1:0] wr_beat_ff;
   ptr_t                  wr_slot_ff;
   logic [ENTRY_W-1:0]    wr_buf_ff;
   logic                  mem_we_ff;

   // write latency counted as for an ordinary single write
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         wr_state_ff <= XF_IDLE;
         wr_lat_ff   <= LAT_ZERO;
         wr_beat_ff  <= '0;
         wr_slot_ff  <= PTR_RST;
      end else begin
         case (wr_state_ff)
            XF_IDLE: begin
               if (wr_go) begin
                  wr_slot_ff  <= wr_ptr_ff;
                  wr_lat_ff   <= mode_in.wr_lat;
                  wr_state_ff <= (mode_in.wr_lat > LAT_ONE) ? XF_WAIT
                                                            : XF_BURST;
                  wr_beat_ff  <= '0;
               end
            end
            XF_WAIT: begin
               wr_lat_ff <= wr_lat_ff - LAT_ONE;
               if (wr_lat_ff <= (LAT_ONE + LAT_ONE)) begin
                  wr_state_ff <= XF_BURST;
               end
            end
            XF_BURST: begin
               wr_beat_ff <= wr_beat_ff + 4'h1;
               if (wr_beat_ff == BEAT_LAST) begin
                  wr_state_ff <= XF_IDLE;
               end
            end
            default: wr_state_ff <= XF_IDLE;
         endcase
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (wr_state_ff == XF_BURST) begin
         wr_buf_ff[wr_beat_ff*BEAT_W +: BEAT_W] <= {lane_in, dq_in};
      end
   end

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         mem_we_ff <= 1'b0;
      end else begin
         mem_we_ff <= (wr_state_ff == XF_BURST) & (wr_beat_ff == BEAT_LAST);
      end
   end

   // ------------------------------------------------------------------
   // storage; entries never written simply return stale contents
   // ------------------------------------------------------------------
   logic [ENTRY_W-1:0] rd_entry;

   train_mem u_mem (
      .core_clk_in (core_clk_in),
      .wr_en_in    (mem_we_ff),
      .wr_addr_in  (wr_slot_ff),
      .wr_data_in  (wr_buf_ff),
      .rd_addr_in  (rd_slot_ff),
      .rd_data_out (rd_entry)
   );

   // ------------------------------------------------------------------
   // read burst return
   // ------------------------------------------------------------------
   logic [LAT_W-1:0]      rd_lat_ff;
   logic                  rd_wait_ff;
   logic                  rd_burst_ff;
   logic [BEAT_CNT_W-1:0] rd_beat_ff;
   logic [ENTRY_W-1:0]    rd_buf_ff;
   logic                  rd_load_ff;
   logic                  lane_drv;

   // a new read restarts the latency count and drops a read still waiting, so
   // only reads spaced more than rd_lat clocks apart stream without gaps
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rd_lat_ff  <= LAT_ZERO;
         rd_wait_ff <= 1'b0;
         rd_load_ff <= 1'b0;
         rd_slot_ff <= PTR_RST;
      end else begin
         rd_load_ff <= 1'b0;
         if (rd_go) begin
            rd_lat_ff  <= mode_in.rd_lat;
            // hold the entry before the pointer moves on
            rd_slot_ff <= rd_ptr_ff;
            rd_wait_ff <= 1'b1;
         end else if (rd_wait_ff) begin
            rd_lat_ff <= rd_lat_ff - LAT_ONE;
            if (rd_lat_ff <= LAT_ONE) begin
               rd_wait_ff <= 1'b0;
               rd_load_ff <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rd_burst_ff <= 1'b0;
         rd_beat_ff  <= '0;
      end else if (rd_load_ff) begin
         rd_burst_ff <= 1'b1;
         rd_beat_ff  <= '0;
      end else if (rd_burst_ff) begin
         rd_beat_ff <= rd_beat_ff + 4'h1;
         if (rd_beat_ff == BEAT_LAST) begin
            rd_burst_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rd_load_ff) begin
         rd_buf_ff <= rd_entry;
      end
   end

   assign lane_drv = mode_in.wr_inv_en | mode_in.rd_inv_en
                   | mode_in.mask_en;

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         dq_out        <= '0;
         lane_out      <= '0;
         dq_oe_n_out   <= 1'b1;
         lane_oe_n_out <= 1'b1;
      end else begin
         dq_oe_n_out   <= ~rd_burst_ff;
         lane_oe_n_out <= ~(rd_burst_ff & lane_drv);
         if (rd_burst_ff) begin
            {lane_out, dq_out} <= rd_buf_ff[rd_beat_ff*BEAT_W +: BEAT_W];
         end
      end
   end

   // ------------------------------------------------------------------
   // interval oscillator
   // ------------------------------------------------------------------
   osc_state_e       osc_state_ff;
   logic [CNT_W-1:0] osc_cnt_ff;
   logic [TMR_W-1:0] run_left_ff;
   logic             osc_halt;

   // with the timer set the stop command is illegal and ignored
   assign osc_halt = (mode_in.run_timer == TMR_AUTO_OFF)
                   ? osc_stop_cmd
                   : (run_left_ff == TMR_ONE);

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         osc_state_ff <= OSC_IDLE;
         run_left_ff  <= TMR_AUTO_OFF;
      end else begin
         case (osc_state_ff)
            OSC_IDLE, OSC_DONE: begin
               if (osc_start_cmd) begin
                  osc_state_ff <= OSC_RUN;
                  run_left_ff  <= mode_in.run_timer;
               end else begin
                  osc_state_ff <= OSC_IDLE;
               end
            end
            OSC_RUN: begin
               run_left_ff <= run_left_ff - TMR_ONE;
               if (osc_halt) begin
                  osc_state_ff <= OSC_DONE;
               end
            end
            default: osc_state_ff <= OSC_IDLE;
         endcase
      end
   end

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         osc_cnt_ff <= CNT_ZERO;
      end else if (osc_start_cmd && osc_state_ff != OSC_RUN) begin
         osc_cnt_ff <= CNT_ZERO;
      end else if (osc_state_ff == OSC_RUN && osc_tick_in
                   && osc_cnt_ff != CNT_MAX) begin
         osc_cnt_ff <= osc_cnt_ff + 16'h0001;
      end
   end

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         osc_count_low_out  <= '0;
         osc_count_high_out <= '0;
      end else if (osc_state_ff == OSC_RUN && osc_halt) begin
         osc_count_low_out  <= osc_cnt_ff[TMR_W-1:0];
         osc_count_high_out <= osc_cnt_ff[CNT_W-1:TMR_W];
      end
   end

   assign osc_busy_out = (osc_state_ff == OSC_RUN);

endmodule

// ### rtl/train_pkg.sv
// Purpose: shared constants and types for the training fifo and strobe osc
// Assumes: commands arrive pre-decoded from the command/address front end
// Notes:   one entry holds a 16-beat burst of 16 data plus 2 lane bits
package train_pkg;

   localparam int          FIFO_DEPTH   = 5;
   localparam int          PTR_W        = 3;
   localparam int          BEATS        = 16;
   localparam int          DQ_W         = 16;
   localparam int          LANE_W       = 2;
   localparam int          BEAT_W       = DQ_W + LANE_W;
   localparam int          ENTRY_W      = BEATS * BEAT_W;
   localparam int          CNT_W        = 16;
   localparam int          TMR_W        = 8;
   localparam int          BEAT_CNT_W   = 4;
   localparam int          LAT_W        = 6;

   localparam logic [PTR_W-1:0]      PTR_RST   = 3'h0;
   localparam logic [PTR_W-1:0]      PTR_LAST  = 3'h4;
   localparam logic [CNT_W-1:0]      CNT_ZERO  = 16'h0000;
   localparam logic [CNT_W-1:0]      CNT_MAX   = 16'hffff;
   localparam logic [TMR_W-1:0]      TMR_AUTO_OFF = 8'h00;
   localparam logic [TMR_W-1:0]      TMR_ONE   = 8'h01;
   localparam logic [BEAT_CNT_W-1:0] BEAT_LAST = 4'hf;
   localparam logic [LAT_W-1:0]      LAT_ONE   = 6'h01;
   localparam logic [LAT_W-1:0]      LAT_ZERO  = 6'h00;

   // multi-purpose command operand codes, low six bits when select bit high
   localparam logic [5:0]  OP_WR_FIFO   = 6'h07;
   localparam logic [5:0]  OP_RD_FIFO   = 6'h01;
   localparam logic [5:0]  OP_OSC_START = 6'h0b;
   localparam logic [5:0]  OP_OSC_STOP  = 6'h0d;
   localparam int          SEL_BIT      = 6;

   typedef logic [PTR_W-1:0] ptr_t;

   // one command edge, already decoded from the bus
   typedef struct packed {
      logic       mpc_valid;     // multi-purpose command
      logic [6:0] mpc_op;        // operand, bit 6 is the train select
      logic       cas2_valid;    // second-part column command
      logic       rd_valid;      // ordinary read, with or without precharge
      logic       pd_entry;      // power-down or self-refresh power-down
   } cmd_s;

   // mode register settings steering this block
   typedef struct packed {
      logic             wr_inv_en;
      logic             rd_inv_en;
      logic             mask_en;
      logic [TMR_W-1:0] run_timer;  // zero: stop by command
      logic [LAT_W-1:0] wr_lat;
      logic [LAT_W-1:0] rd_lat;
   } mode_s;

   typedef enum logic [1:0] {
      OSC_IDLE = 2'b00,
      OSC_RUN  = 2'b01,
      OSC_DONE = 2'b11
   } osc_state_e;

   typedef enum logic [1:0] {
      XF_IDLE = 2'b00,
      XF_WAIT = 2'b01,
      XF_BURST = 2'b11
   } xfer_state_e;

endpackage

// ### tb/ctrl_model.sv
// Purpose: memory controller issuing training commands and ticks
// Assumes: drives on the falling edge, write latency of one
// Notes:   released data lines show the inverse of the last beat
`timescale 1ns/1ps
module ctrl_model (
   input  wire logic                     clk_in,
   output train_pkg::cmd_s               cmd_out,
   output logic [train_pkg::DQ_W-1:0]    dq_out,
   output logic [train_pkg::LANE_W-1:0]  lane_out,
   output logic                          tick_out
);
   import train_pkg::*;
   // row-to-column delay plus three clocks, plain default
   localparam int PD_WR_WAIT = 8;
   initial begin
      cmd_out  = '0;
      dq_out   = '0;
      lane_out = '0;
      tick_out = 1'b0;
   end
   function automatic logic [BEAT_W-1:0] pattern(input logic [7:0] e,
                                                  input int k);
      return {k[1:0] ^ e[1:0], e ^ 8'h3c, 4'h9, k[3:0]};
   endfunction
   task automatic send(input cmd_s c);
      @(negedge clk_in);
      cmd_out = c;
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge clk_in);
   endtask
   task automatic multi_purpose_cmd(input logic [6:0] op);
      cmd_s c;
      c = '0;
      c.mpc_valid = 1'b1;
      c.mpc_op = op;
      send(c);
      send('0);
   endtask
   task automatic fifo(input logic [5:0] op, input logic [7:0] e);
      cmd_s c;
      c = '0;
      c.mpc_valid = 1'b1;
      c.mpc_op = {1'b1, op};
      send(c);
      c = '0;
      c.cas2_valid = 1'b1; // operands held low
      send(c);
      send('0);
      if (op == OP_WR_FIFO) begin
         for (int k = 0; k < BEATS; k++) begin
            if (k > 0) @(negedge clk_in);
            {lane_out, dq_out} = pattern(e, k);
         end
         @(negedge clk_in);
         {lane_out, dq_out} = ~{lane_out, dq_out};
      end
      else idle(13); // reads every sixteen clocks
   endtask
   task automatic osc_stop();
      multi_purpose_cmd({1'b1, OP_OSC_STOP}); // only with timer off
      idle(8); // wait before readout
   endtask
   task automatic pd_wait();
      idle(PD_WR_WAIT);
   endtask
   task automatic ticks(input int n, input int gap);
      repeat (n) begin
         @(negedge clk_in);
         tick_out = 1'b1;
         repeat (gap) @(negedge clk_in) tick_out = 1'b0;
      end
      @(negedge clk_in);
      tick_out = 1'b0;
   endtask
endmodule

// ### tb/train_osc_fifo_assertions.sv
// Purpose: port checks for the training fifo and strobe oscillator
// Assumes: rd_lat one and run_timer eight where latency is checked
// Notes:   bound to every train_osc_fifo instance
`timescale 1ns/1ps
module train_osc_fifo_assertions (
   input wire logic                    core_clk_in,
   input wire logic                    arst_n_in,
   input wire train_pkg::cmd_s         cmd_in,
   input wire train_pkg::mode_s        mode_in,
   input wire logic                    dq_oe_n_out,
   input wire logic                    lane_oe_n_out,
   input wire logic [7:0]              osc_count_low_out,
   input wire logic [7:0]              osc_count_high_out,
   input wire logic                    osc_busy_out
);
   import train_pkg::*;
   logic [7:0] run_ff;
   // counts sampled low cycles of the data enable
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) run_ff <= 8'h00;
      else if (dq_oe_n_out) run_ff <= 8'h00;
      else run_ff <= run_ff + 8'h01;
   end
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!arst_n_in);
   sequence start_s;
      cmd_in.mpc_valid && cmd_in.mpc_op == {1'b1, OP_OSC_START}
         && !osc_busy_out;
   endsequence
   sequence stop_s;
      cmd_in.mpc_valid && cmd_in.mpc_op == {1'b1, OP_OSC_STOP};
   endsequence
   sequence rd_s;
      cmd_in.mpc_valid && cmd_in.mpc_op == {1'b1, OP_RD_FIFO}
         ##1 cmd_in.cas2_valid;
   endsequence
   chk_start_busy: assert property (start_s |=> osc_busy_out)
      else $error("busy did not rise after start");
   chk_nop_idle: assert property (cmd_in.mpc_valid
      && !cmd_in.mpc_op[SEL_BIT] && !osc_busy_out |=> !osc_busy_out)
      else $error("no-operation command started oscillator");
   chk_stop_cmd: assert property ((osc_busy_out
      && mode_in.run_timer == TMR_AUTO_OFF) ##0 stop_s |=> !osc_busy_out)
      else $error("stop command did not stop oscillator");
   chk_busy_hold: assert property (osc_busy_out
      && mode_in.run_timer == TMR_AUTO_OFF && !(cmd_in.mpc_valid
      && cmd_in.mpc_op == {1'b1, OP_OSC_STOP}) |=> osc_busy_out)
      else $error("oscillator stopped without command");
   chk_timer_stop: assert property (start_s ##0
      (mode_in.run_timer == 8'h08) |=>
      osc_busy_out [*8] ##[1:2] !osc_busy_out)
      else $error("run timer stop out of place");
   chk_counts_hold: assert property (!osc_busy_out [*3] |->
      $stable({osc_count_high_out, osc_count_low_out}))
      else $error("result changed while idle");
   chk_lane_off: assert property (!lane_oe_n_out |->
      mode_in.wr_inv_en || mode_in.rd_inv_en || mode_in.mask_en)
      else $error("lane driven with lane functions off");
   chk_burst_len: assert property ($rose(dq_oe_n_out) |->
      run_ff[3:0] == 4'h0 && run_ff != 8'h00)
      else $error("burst not a multiple of sixteen beats");
   chk_rd_lat: assert property (rd_s ##0
      (mode_in.rd_lat == LAT_ONE) |-> ##[4:5] !dq_oe_n_out)
      else $error("fifo read data late");
endmodule
bind train_osc_fifo train_osc_fifo_assertions chk_u (
   .core_clk_in        (core_clk_in),
   .arst_n_in          (arst_n_in),
   .cmd_in             (cmd_in),
   .mode_in            (mode_in),
   .dq_oe_n_out        (dq_oe_n_out),
   .lane_oe_n_out      (lane_oe_n_out),
   .osc_count_low_out  (osc_count_low_out),
   .osc_count_high_out (osc_count_high_out),
   .osc_busy_out       (osc_busy_out)
);

// ### tb/train_osc_fifo_tb.sv
// Purpose: self-checking bench for the training fifo and oscillator
// Assumes: write latency one clock, read latency one or two clocks
// Notes:   a monitor collects every driven read beat
`timescale 1ns/1ps
module train_osc_fifo_tb;
   import train_pkg::*;
   logic clk, arst_n;
   mode_s mode;
   cmd_s cmd;
   logic tick;
   logic clk_en;
   logic [DQ_W-1:0] dqi, dqo;
   logic [LANE_W-1:0] lni, lno;
   logic dq_oe_n, ln_oe_n, busy;
   logic [7:0] cl, ch;
   logic [18:0] got[$];
   int failures, checks;
   ctrl_model mdl_u (.clk_in(clk), .cmd_out(cmd), .dq_out(dqi),
                     .lane_out(lni), .tick_out(tick));
   train_osc_fifo dut_u (
      .core_clk_in(clk), .arst_n_in(arst_n), .cmd_in(cmd),
      .mode_in(mode), .clk_en_in(clk_en), .osc_tick_in(tick),
      .dq_in(dqi), .lane_in(lni), .dq_out(dqo), .dq_oe_n_out(dq_oe_n),
      .lane_out(lno), .lane_oe_n_out(ln_oe_n), .osc_count_low_out(cl),
      .osc_count_high_out(ch), .osc_busy_out(busy));
   initial clk = 1'b0;
   always #50 clk = ~clk;
   always @(negedge clk) if (dq_oe_n === 1'b0)
      got.push_back({ln_oe_n, lno, dqo});
   task automatic cmp(input logic [18:0] g, e, input string m);
      checks++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask
   task automatic cmp_reads(input int n, s, st, input logic on);
      logic [18:0] e, g;
      cmp(19'(got.size()), 19'(n * 16), "beat count");
      for (int i = 0; i < n * 16 && i < got.size(); i++) begin
         e = {~on, mdl_u.pattern(8'((s + (i / 16) * st) % 5), i % 16)};
         g = got[i];
         if (!on) begin
            e[17:16] = 2'b00;
            g[17:16] = 2'b00;
         end
         cmp(g, e, "read beat");
      end
   endtask
   task automatic stop_test();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic t_osc_cmd();
      mdl_u.multi_purpose_cmd({1'b1, OP_OSC_START});
      mdl_u.ticks(10, 1);
      mdl_u.osc_stop();
      cmp(19'({ch, cl}), 19'd10, "count by command");
      cmp(19'(busy), 19'd0, "busy after stop");
      mdl_u.multi_purpose_cmd({1'b0, OP_OSC_START});
      mdl_u.idle(2);
      cmp(19'(busy), 19'd0, "busy after no-op");
      $display("test osc_cmd done");
   endtask
   task automatic t_osc_timer();
      mode.run_timer = 8'h08;
      mdl_u.multi_purpose_cmd({1'b1, OP_OSC_START});
      mdl_u.ticks(3, 1);
      mdl_u.idle(10);
      cmp(19'(busy), 19'd0, "busy after timer");
      cmp(19'({ch, cl}), 19'd3, "count by timer");
      mode.run_timer = TMR_AUTO_OFF;
      $display("test osc_timer done");
   endtask
   task automatic t_osc_sat();
      mdl_u.multi_purpose_cmd({1'b1, OP_OSC_START});
      mdl_u.ticks(65540, 0);
      mdl_u.osc_stop();
      cmp(19'({ch, cl}), 19'(CNT_MAX), "saturated count");
      $display("test osc_sat done");
   endtask
   task automatic t_fifo();
      mode.mask_en = 1'b1;
      got.delete();
      for (int e = 0; e < 5; e++) mdl_u.fifo(OP_WR_FIFO, 8'(e));
      mode.mask_en = 1'b0;
      mode.rd_inv_en = 1'b1;
      for (int r = 0; r < 6; r++) mdl_u.fifo(OP_RD_FIFO, 8'h00);
      mdl_u.idle(8);
      cmp_reads(6, 0, 1, 1'b1);
      $display("test fifo done");
   endtask
   task automatic t_ptr();
      cmd_s c;
      mode.rd_inv_en = 1'b0;
      mode.wr_inv_en = 1'b1;
      mode.rd_lat = LAT_ONE + LAT_ONE;
      got.delete();
      c = '0;
      c.pd_entry = 1'b1;
      mdl_u.send(c);
      mdl_u.send('0);
      mdl_u.fifo(OP_RD_FIFO, 8'h00);
      c = '0;
      c.rd_valid = 1'b1;
      mdl_u.send(c);
      mdl_u.send('0);
      mdl_u.fifo(OP_RD_FIFO, 8'h00);
      mdl_u.idle(8);
      cmp_reads(2, 0, 2, 1'b1);
      $display("test ptr done");
   endtask
   task automatic t_cke();
      cmd_s c;
      mode.wr_inv_en = 1'b0;
      mode.rd_lat = LAT_ONE;
      got.delete();
      @(negedge clk) clk_en = 1'b0;
      mdl_u.fifo(OP_WR_FIFO, 8'h04);
      @(negedge clk) clk_en = 1'b1;
      mdl_u.pd_wait();
      mdl_u.fifo(OP_RD_FIFO, 8'h00);
      mdl_u.fifo(OP_WR_FIFO, 8'h02);
      c = '0;
      c.pd_entry = 1'b1;
      mdl_u.send(c);
      mdl_u.send('0);
      mdl_u.fifo(OP_RD_FIFO, 8'h00);
      mdl_u.idle(8);
      cmp_reads(2, 0, 2, 1'b0);
      $display("test cke done");
   endtask
   initial begin
      arst_n = 1'b0;
      mode = '0;
      clk_en = 1'b1;
      mode.wr_lat = LAT_ONE;
      mode.rd_lat = LAT_ONE;
      repeat (4) @(posedge clk);
      @(negedge clk) arst_n = 1'b1;
      t_osc_cmd();
      t_osc_timer();
      t_osc_sat();
      t_fifo();
      t_ptr();
      t_cke();
      stop_test();
   end
   initial begin
      #8000000;
      failures++;
      $display("[FAIL] %0t watchdog expired", $time);
      stop_test();
   end
endmodule
